// ### rtl/dfb_top.sv
// drive fault latch, pwm gate kill, brake control and status led
//
// The placing of the registers and the Wishbone interface to the registers were decided locally.
`timescale 1ns/1ps
module dfb_top
	import dfb_pkg::*;
(
	input wire logic clk_i, // system clock
	input wire logic rst_i, // sync reset, active high
	input wire logic ce_i, // clock enable, freezes state when low
	input wire logic wb_cyc_i, // wishbone cycle
	input wire logic wb_stb_i, // wishbone strobe
	input wire logic wb_we_i, // wishbone write
	input wire logic [ADDR_W-1:0] wb_adr_i, // byte address
	input wire logic [3:0] wb_sel_i, // byte lanes
	input wire logic [31:0] wb_dat_i, // write data
	output logic [31:0] wb_dat_o, // read data
	output logic wb_ack_o, // acknowledge
	input wire logic gate_trip_i, // power stage trip, active high
	input wire logic fault_clear_pin_n_i, // external clear, active low
	input wire logic config_done_i, // configuration complete
	input wire logic [VBUS_W-1:0] vbus_i, // dc bus voltage, volts
	input wire logic [5:0] pwm_gate_i, // gate requests from modulator
	output logic [5:0] pwm_gate_o, // gate outputs
	output logic pwm_output_enable_o, // pwm output enable bit
	output logic vector_control_enable_o, // vector control enable bit
	output logic brake_o, // brake transistor drive
	output logic fault_n_o, // fault pin, low on fault
	output logic [1:0] led_o // status led, 1 green 2 red
);
	dfb_bus_if vif ();
	assign vif.vbus = vbus_i;
	dfb_vbus_mon u_mon (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.mon(vif.mon)
	);

	logic pwm_output_enable_bit;
	logic vector_control_enable_bit;
	logic fault_clear_bit;
	logic fault_pend;
	logic trip_seen;
	logic ov_seen;
	logic uv_seen;
	logic pin_d;
	dfb_clr_type clr_state;
	logic next_pwm_output_enable_bit;
	logic next_vector_control_enable_bit;
	logic next_fault_clear_bit;
	logic next_fault_pend;
	logic next_trip_seen;
	logic next_ov_seen;
	logic next_uv_seen;
	dfb_clr_type next_clr_state;
	logic [31:0] next_dat;
	logic next_ack;
	logic req;
	logic wr;
	logic pin_fall;
	logic clr_req;
	logic arm;
	logic any_src;
	logic sel_sys;
	logic sel_fault;
	logic sel_stat;
	logic sel_dcbus;
	logic gate_kill;
	wire logic [5:0] next_pwm_gate;
	logic next_fault_n;
	logic [1:0] next_led;

	assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wr = req & wb_we_i & wb_sel_i[0];
	// falling edge of the low-true clear pin counts as a request
	assign pin_fall = pin_d & ~fault_clear_pin_n_i;
	assign any_src = gate_trip_i | vif.ov | vif.uv;

	always_comb
	begin
		next_clr_state = clr_state;
		case (clr_state)
			DFB_CLR_IDLE:
				if (pin_fall)
					next_clr_state = DFB_CLR_HELD;
			DFB_CLR_HELD:
				if (fault_clear_pin_n_i)
					next_clr_state = DFB_CLR_IDLE;
			default:
				next_clr_state = DFB_CLR_IDLE;
		endcase
	end

	// clear wins while asserted; new faults latch only once armed again
	assign clr_req = fault_clear_bit | pin_fall |
		(clr_state == DFB_CLR_HELD);
	assign arm = ~clr_req;

	always_comb
	begin
		next_fault_pend = fault_pend;
		next_trip_seen = trip_seen;
		next_ov_seen = ov_seen;
		next_uv_seen = uv_seen;
		if (!arm)
		begin
			next_fault_pend = 1'b0;
			next_trip_seen = 1'b0;
			next_ov_seen = 1'b0;
			next_uv_seen = 1'b0;
		end
		else
		begin
			if (any_src)
				next_fault_pend = 1'b1;
			if (gate_trip_i)
				next_trip_seen = 1'b1;
			if (vif.ov)
				next_ov_seen = 1'b1;
			if (vif.uv)
				next_uv_seen = 1'b1;
		end
	end

	// address decode shared by the write and read paths
	always_comb
	begin
		sel_sys = 1'b0;
		sel_fault = 1'b0;
		sel_stat = 1'b0;
		sel_dcbus = 1'b0;
		if (wb_adr_i == SYS_CTRL_ADDR)
			sel_sys = 1'b1;
		else if (wb_adr_i == FAULT_CTRL_ADDR)
			sel_fault = 1'b1;
		else if (wb_adr_i == FAULT_STAT_ADDR)
			sel_stat = 1'b1;
		else if (wb_adr_i == DC_BUS_ADDR)
			sel_dcbus = 1'b1;
	end

	always_comb
	begin
		next_pwm_output_enable_bit = pwm_output_enable_bit;
		next_vector_control_enable_bit = vector_control_enable_bit;
		next_fault_clear_bit = fault_clear_bit;
		if (wr && sel_sys)
		begin
			next_pwm_output_enable_bit = wb_dat_i[PWM_EN_POS];
			next_vector_control_enable_bit = wb_dat_i[VEC_EN_POS];
		end
		else if (wr && sel_fault)
			next_fault_clear_bit = wb_dat_i[FLT_CLR_POS];
		// fault forcing beats a software enable in the same cycle
		if (fault_pend || (arm && any_src))
		begin
			next_pwm_output_enable_bit = 1'b0;
			next_vector_control_enable_bit = 1'b0;
		end
	end

	always_comb
	begin
		next_dat = ZERO_WORD;
		if (sel_sys)
		begin
			next_dat[PWM_EN_POS] = pwm_output_enable_bit;
			next_dat[VEC_EN_POS] = vector_control_enable_bit;
		end
		else if (sel_fault)
			next_dat[FLT_CLR_POS] = fault_clear_bit;
		else if (sel_stat)
		begin
			next_dat[ST_TRIP_POS] = trip_seen;
			next_dat[ST_OV_POS] = ov_seen;
			next_dat[ST_UV_POS] = uv_seen;
			next_dat[ST_PEND_POS] = fault_pend;
		end
		else if (sel_dcbus)
		begin
			next_dat[VBUS_W-1:0] = vbus_i;
			next_dat[BRAKE_POS] = vif.brake;
		end
		if (!req || wb_we_i)
			next_dat = ZERO_WORD;
		next_ack = req;
	end

	// trip acts straight on the gates, not via the latch
	assign gate_kill = gate_trip_i | next_fault_pend |
		~next_pwm_output_enable_bit;

	// one mask per gate leg keeps the kill path identical on all six
	for (genvar g = 0; g < $bits(pwm_gate_i); g++)
	begin : g_gate
		assign next_pwm_gate[g] = pwm_gate_i[g] & ~gate_kill;
	end

	always_comb
	begin
		next_fault_n = ~next_fault_pend;
		if (!config_done_i)
			next_led = LED_OFF;
		else if (next_fault_pend)
			next_led = LED_RED;
		else
			next_led = LED_GREEN;
	end

	// software-visible control bits
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			pwm_output_enable_bit <= 1'b0;
			vector_control_enable_bit <= 1'b0;
			fault_clear_bit <= 1'b0;
		end
		else if (ce_i)
		begin
			pwm_output_enable_bit <= next_pwm_output_enable_bit;
			vector_control_enable_bit <= next_vector_control_enable_bit;
			fault_clear_bit <= next_fault_clear_bit;
		end
	end

	// shared fault latch, sticky causes and clear-pin tracking
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			fault_pend <= 1'b0;
			trip_seen <= 1'b0;
			ov_seen <= 1'b0;
			uv_seen <= 1'b0;
			// idle level of the pin, so no false edge after reset
			pin_d <= 1'b1;
			clr_state <= DFB_CLR_IDLE;
		end
		else if (ce_i)
		begin
			fault_pend <= next_fault_pend;
			trip_seen <= next_trip_seen;
			ov_seen <= next_ov_seen;
			uv_seen <= next_uv_seen;
			pin_d <= fault_clear_pin_n_i;
			clr_state <= next_clr_state;
		end
	end

	// bus answer
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wb_dat_o <= ZERO_WORD;
			wb_ack_o <= 1'b0;
		end
		else if (ce_i)
		begin
			wb_dat_o <= next_dat;
			wb_ack_o <= next_ack;
		end
	end

	// pin-facing outputs, all registered
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			pwm_gate_o <= '0;
			pwm_output_enable_o <= 1'b0;
			vector_control_enable_o <= 1'b0;
			brake_o <= 1'b0;
			fault_n_o <= 1'b1;
			led_o <= LED_OFF;
		end
		else if (ce_i)
		begin
			pwm_gate_o <= next_pwm_gate;
			pwm_output_enable_o <= next_pwm_output_enable_bit;
			vector_control_enable_o <= next_vector_control_enable_bit;
			brake_o <= vif.brake;
			fault_n_o <= next_fault_n;
			led_o <= next_led;
		end
	end
endmodule : dfb_top

// ### rtl/dfb_pkg.sv
// constants, register map and types for the drive fault and brake block
package dfb_pkg;
	localparam int ADDR_W = 4;
	localparam logic [ADDR_W-1:0] SYS_CTRL_ADDR = 4'h0;
	localparam logic [ADDR_W-1:0] FAULT_CTRL_ADDR = 4'h4;
	localparam logic [ADDR_W-1:0] FAULT_STAT_ADDR = 4'h8;
	localparam logic [ADDR_W-1:0] DC_BUS_ADDR = 4'hC;
	localparam int PWM_EN_POS = 0;
	localparam int VEC_EN_POS = 1;
	localparam int FLT_CLR_POS = 0;
	localparam int ST_TRIP_POS = 0;
	localparam int ST_OV_POS = 1;
	localparam int ST_UV_POS = 2;
	localparam int ST_PEND_POS = 3;
	localparam int BRAKE_POS = 15;
	localparam int VBUS_W = 12;
	// bus voltage is sampled in whole volts
	localparam logic [VBUS_W-1:0] VBUS_OV = 12'h19A;
	localparam logic [VBUS_W-1:0] VBUS_BRAKE_ON = 12'h17C;
	localparam logic [VBUS_W-1:0] VBUS_BRAKE_OFF = 12'h168;
	localparam logic [VBUS_W-1:0] VBUS_UV = 12'h078;
	localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
	localparam logic [1:0] LED_OFF = 2'h0;
	localparam logic [1:0] LED_GREEN = 2'h1;
	localparam logic [1:0] LED_RED = 2'h2;
	typedef enum logic [1:0] {DFB_CLR_IDLE, DFB_CLR_HELD} dfb_clr_type;
endpackage : dfb_pkg

// ### rtl/dfb_bus_if.sv
// voltage monitor results carried between the monitor and the top
`timescale 1ns/1ps
interface dfb_bus_if;
	logic [dfb_pkg::VBUS_W-1:0] vbus;
	logic brake;
	logic ov;
	logic uv;
	modport mon (input vbus, output brake, ov, uv);
	modport top (output vbus, input brake, ov, uv);
endinterface : dfb_bus_if

// ### rtl/dfb_vbus_mon.sv
// dc bus brake hysteresis and over/undervoltage compare
`timescale 1ns/1ps
module dfb_vbus_mon
	import dfb_pkg::*;
(
	input wire logic clk_i, // system clock
	input wire logic rst_i, // sync reset
	input wire logic ce_i, // clock enable
	dfb_bus_if.mon mon // bus voltage and results
);
	logic brake;
	logic next_brake;
	logic ov;
	logic uv;
	logic next_ov;
	logic next_uv;
	always_comb
	begin
		next_brake = brake;
		if (mon.vbus > VBUS_BRAKE_ON)
			next_brake = 1'b1;
		else if (mon.vbus < VBUS_BRAKE_OFF)
			next_brake = 1'b0;
		next_ov = (mon.vbus >= VBUS_OV);
		next_uv = (mon.vbus < VBUS_UV);
	end
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			brake <= 1'b0;
			ov <= 1'b0;
			uv <= 1'b0;
		end
		else if (ce_i)
		begin
			brake <= next_brake;
			ov <= next_ov;
			uv <= next_uv;
		end
	end
	assign mon.brake = brake;
	assign mon.ov = ov;
	assign mon.uv = uv;
endmodule : dfb_vbus_mon

// ### bench/dfb_chk.sv
// port assertions for the drive fault and brake block
`timescale 1ns/1ps
module dfb_chk
	import dfb_pkg::*;
(
	input wire logic clk_i, // clock
	input wire logic rst_i, // reset
	input wire logic ce_i, // enable
	input wire logic wb_cyc_i, // cycle
	input wire logic wb_stb_i, // strobe
	input wire logic wb_ack_o, // ack
	input wire logic gate_trip_i, // trip
	input wire logic config_done_i, // configured
	input wire logic [VBUS_W-1:0] vbus_i, // volts
	input wire logic [5:0] pwm_gate_o, // gates
	input wire logic pwm_output_enable_o, // enable
	input wire logic brake_o, // brake
	input wire logic fault_n_o, // fault pin
	input wire logic [1:0] led_o // led
);
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	sequence s_hi;
		(ce_i && vbus_i > VBUS_BRAKE_ON)[*2];
	endsequence
	sequence s_lo;
		(ce_i && vbus_i < VBUS_BRAKE_OFF)[*2];
	endsequence
	// led is judged only once reset and freeze are out of the last edge
	sequence s_run;
		$past(ce_i) && !$past(rst_i);
	endsequence
	property p_ack;
		wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o;
	endproperty
	property p_trip;
		ce_i && gate_trip_i |-> ##[1:2] pwm_gate_o == 6'h00;
	endproperty
	property p_en;
		$fell(fault_n_o) |-> ##[0:1] !pwm_output_enable_o;
	endproperty
	property p_bon;
		s_hi |=> brake_o;
	endproperty
	property p_bhold;
		brake_o && $past(vbus_i) >= VBUS_BRAKE_OFF |=> brake_o;
	endproperty
	property p_boff;
		s_lo |=> !brake_o;
	endproperty
	property p_dark;
		s_run ##0 !$past(config_done_i) |-> led_o == LED_OFF;
	endproperty
	property p_green;
		s_run ##0 $past(config_done_i) && fault_n_o |-> led_o == LED_GREEN;
	endproperty
	property p_red;
		s_run ##0 $past(config_done_i) && !fault_n_o |-> led_o == LED_RED;
	endproperty
	a_ack: assert property (p_ack) else $error("no ack");
	a_trip: assert property (p_trip) else $error("gates on");
	a_en: assert property (p_en) else $error("enable kept");
	a_bon: assert property (p_bon) else $error("brake off");
	a_bhold: assert property (p_bhold) else $error("brake drop");
	a_boff: assert property (p_boff) else $error("brake on");
	a_dark: assert property (p_dark) else $error("led lit");
	a_green: assert property (p_green) else $error("not green");
	a_red: assert property (p_red) else $error("not red");
endmodule : dfb_chk

bind dfb_top dfb_chk i_dfb_chk (.clk_i, .rst_i, .ce_i, .wb_cyc_i,
	.wb_stb_i, .wb_ack_o, .gate_trip_i, .config_done_i, .vbus_i,
	.pwm_gate_o, .pwm_output_enable_o, .brake_o, .fault_n_o, .led_o);

// ### bench/dfb_ipm_model.sv
// power module stand-in: trip line and measured bus voltage
`timescale 1ns/1ps
module dfb_ipm_model
	import dfb_pkg::*;
(
	input wire logic clk_i, // clock
	input wire logic trip_req_i, // bench asks for a trip
	input wire logic [VBUS_W-1:0] volts_i, // bus level to show
	output logic gate_trip_o, // trip to device
	output logic [VBUS_W-1:0] vbus_o // measured bus
);
	// one register stage, as the opto path and adc both add delay
	always_ff @(posedge clk_i)
	begin
		gate_trip_o <= trip_req_i;
		vbus_o <= volts_i;
	end
endmodule : dfb_ipm_model

// ### bench/dfb_top_tb.sv
// self-checking bench for the drive fault and brake block
`timescale 1ns/1ps
module dfb_top_tb;
	import dfb_pkg::*;
	logic clk_i, rst_i, cyc, we, ack, trip_req, trip, pin_n, cfg;
	logic pen, ven, brake, flt_n, ce;
	logic [3:0] adr;
	logic [31:0] wd, rd;
	logic [11:0] volts, vbus;
	logic [5:0] gates;
	logic [1:0] led;
	int n_fail = 0;
	int compares = 0;
	dfb_ipm_model i_dfb_ipm_model (.clk_i(clk_i), .trip_req_i(trip_req),
		.volts_i(volts), .gate_trip_o(trip), .vbus_o(vbus));
	dfb_top i_dfb_top (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
		.wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(4'hF), .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack),
		.gate_trip_i(trip), .fault_clear_pin_n_i(pin_n),
		.config_done_i(cfg), .vbus_i(vbus), .pwm_gate_i(6'h2A),
		.pwm_gate_o(gates), .pwm_output_enable_o(pen),
		.vector_control_enable_o(ven), .brake_o(brake),
		.fault_n_o(flt_n), .led_o(led));
	task automatic give_verdict;
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : give_verdict
	task automatic chk(input string s, input logic [31:0] v, e);
		compares++;
		if (v !== e)
		begin
			n_fail++;
			$display("Error %s exp %h seen %h", s, e, v);
		end
	endtask : chk
	task automatic wb(input logic w, input logic [3:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wd <= d;
		do
			@(posedge clk_i);
		while (ack !== 1'b1 && ++n < 30);
		q = rd;
		cyc <= 1'b0;
		if (n == 30)
		begin
			n_fail++;
			give_verdict;
		end
		else
			@(posedge clk_i);
	endtask : wb
	task automatic wait_n(input int n);
		repeat (n) @(posedge clk_i);
	endtask : wait_n
	task automatic t_ce;
		ce <= 1'b0;
		volts <= 12'h181;
		wait_n(4);
		chk("frozen", brake, 1'b0);
		ce <= 1'b1;
		wait_n(4);
		chk("brake", brake, 1'b1);
		volts <= 12'h12C;
		wait_n(4);
		chk("brake", brake, 1'b0);
	endtask : t_ce
	task automatic t_trip;
		logic [31:0] q;
		wb(1, SYS_CTRL_ADDR, 32'h3, q);
		wait_n(2);
		chk("gates", gates, 6'h2A);
		chk("en", {ven, pen}, 2'h3);
		trip_req <= 1'b1;
		wait_n(4);
		chk("gates", gates, 6'h00);
		chk("en", {ven, pen}, 2'h0);
		chk("pin", flt_n, 1'b0);
		chk("led", led, LED_RED);
		wb(0, FAULT_STAT_ADDR, 0, q);
		chk("stat", q, 32'h9);
		wb(1, FAULT_CTRL_ADDR, 32'h1, q);
		wait_n(2);
		chk("pin", flt_n, 1'b1);
		trip_req <= 1'b0;
		wb(1, FAULT_CTRL_ADDR, 32'h0, q);
		chk("gates", gates, 6'h00);
		chk("en", {ven, pen}, 2'h0);
		chk("pin", flt_n, 1'b1);
		trip_req <= 1'b1;
		wait_n(4);
		trip_req <= 1'b0;
		chk("pin", flt_n, 1'b0);
		wb(1, FAULT_CTRL_ADDR, 32'h1, q);
		wb(1, FAULT_CTRL_ADDR, 32'h0, q);
		wb(1, SYS_CTRL_ADDR, 32'h3, q);
		wait_n(2);
		chk("gates", gates, 6'h2A);
	endtask : t_trip
	task automatic t_bus;
		logic [31:0] q;
		logic [11:0] lv [2] = '{VBUS_OV, VBUS_UV - 12'h001};
		logic [31:0] st [2] = '{32'hA, 32'hC};
		volts <= 12'h181;
		wait_n(4);
		chk("brake", brake, 1'b1);
		volts <= 12'h172;
		wait_n(4);
		chk("brake", brake, 1'b1);
		wb(0, DC_BUS_ADDR, 0, q);
		chk("vbus", q, 32'h8172);
		wb(0, 4'h2, 0, q);
		chk("none", q, ZERO_WORD);
		volts <= 12'h163;
		wait_n(4);
		chk("brake", brake, 1'b0);
		for (int i = 0; i < 2; i++)
		begin
			volts <= lv[i];
			wait_n(4);
			chk("pin", flt_n, 1'b0);
			wb(0, FAULT_STAT_ADDR, 0, q);
			chk("stat", q, st[i]);
			volts <= 12'h12C;
			pin_n <= 1'b0;
			wait_n(3);
			pin_n <= 1'b1;
			wait_n(2);
			chk("pin", flt_n, 1'b1);
		end
	endtask : t_bus
	task automatic t_led;
		wait_n(2);
		chk("led", led, LED_GREEN);
		cfg <= 1'b0;
		wait_n(3);
		chk("led", led, LED_OFF);
		cfg <= 1'b1;
		wait_n(3);
	endtask : t_led
	initial
	begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	initial
	begin
		{cyc, we, trip_req, adr, wd} = '0;
		{rst_i, pin_n, cfg} = 3'h7;
		ce = 1'b1;
		volts = 12'h12C;
		wait_n(2);
		rst_i <= 1'b0;
		chk("pin", flt_n, 1'b1);
		t_led;
		t_ce;
		t_trip;
		t_bus;
		give_verdict;
	end
endmodule : dfb_top_tb
